// File: shared/opdec_pkg.sv
package opdec_pkg;

	// ***********************************************
	// Opcode bytes and patterns
	// ***********************************************
	localparam logic [7:0] ESCAPE_BYTE      = 8'h0f; // Two-byte escape
	localparam logic [6:0] SIGN_EXT_HI      = 7'h5f; // 0F B[111w] upper 7 bits
	localparam logic [6:0] ZERO_EXT_HI      = 7'h5b; // 0F B[011w] upper 7 bits
	localparam logic [7:0] INVALID_OP_BYTE  = 8'hff; // 0F FF
	localparam logic [7:0] CTRL_WRITE_BYTE  = 8'h22; // 0F 22
	localparam logic [1:0] MODRM_REG_FORM   = 2'h3;  // mod field 11

	// ***********************************************
	// Clock counts
	// ***********************************************
	localparam logic [6:0] LAT_ONE          = 7'h01; // Single clock
	localparam logic [6:0] LAT_INV_PROT_MIN = 7'h08; // Invalid op, prot min
	localparam logic [6:0] LAT_INV_PROT_MAX = 7'h7d; // Invalid op, prot max
	localparam logic [6:0] LAT_CTRL0_WRITE  = 7'h14; // Write control reg 0
	localparam logic [6:0] LAT_CTRL2_WRITE  = 7'h05; // Write control reg 2
	localparam logic [6:0] LAT_CTRL3_WRITE  = 7'h05; // Write control reg 3

	// ***********************************************
	// Instruction classes
	// ***********************************************
	typedef enum logic [2:0] {
		CLS_NONE      = 3'h0, // Not recognised
		CLS_SIGN_EXT  = 3'h1, // move_sign_extend
		CLS_ZERO_EXT  = 3'h2, // move_zero_extend
		CLS_INVALID   = 3'h3, // reserved_invalid_opcode
		CLS_CTRL_MOVE = 3'h4  // Move into control_registers
	} instr_class_t;

	// Field width codes
	localparam logic [1:0] WID_NONE = 2'h0; // Field absent
	localparam logic [1:0] WID_8    = 2'h1; // 8 bits
	localparam logic [1:0] WID_16   = 2'h2; // 16 bits
	localparam logic [1:0] WID_32   = 2'h3; // 32 bits

	// Flag effect codes
	localparam logic [1:0] FLG_KEEP = 2'h0; // Unchanged
	localparam logic [1:0] FLG_MOD  = 2'h1; // Modified
	localparam logic [1:0] FLG_CLR  = 2'h2; // Cleared

endpackage : opdec_pkg

// File: core/field_width.sv
`timescale 1ns/10ps
`default_nettype none
module field_width (
	input  wire logic       imm_full,  // Encoding has full immediate
	input  wire logic       imm_byte,  // Encoding has 8-bit immediate
	input  wire logic       disp_full, // Encoding has full displacement
	input  wire logic       disp_byte, // Encoding has short displacement
	input  wire logic       op32,      // Operand size is 32
	input  wire logic       addr32,    // Address size is 32
	input  wire logic       w_bit,     // Opcode w bit
	output logic      [1:0] imm_wid,   // Immediate width code
	output logic      [1:0] disp_wid,  // Displacement width code
	output logic      [1:0] opnd_wid   // Operand width code
);

	// ***********************************************
	// Width selection
	// ***********************************************
	// Full operand follows operand size, byte by w bit
	always_comb begin
		opnd_wid = !w_bit ? opdec_pkg::WID_8 :
			(op32 ? opdec_pkg::WID_32 : opdec_pkg::WID_16);
		if (imm_byte || (imm_full && !w_bit))
			imm_wid = opdec_pkg::WID_8;
		else if (imm_full)
			imm_wid = op32 ? opdec_pkg::WID_32 : opdec_pkg::WID_16;
		else
			imm_wid = opdec_pkg::WID_NONE;
		if (disp_byte)
			disp_wid = opdec_pkg::WID_8;
		else if (disp_full)
			disp_wid = addr32 ? opdec_pkg::WID_32 : opdec_pkg::WID_16;
		else
			disp_wid = opdec_pkg::WID_NONE;
	end

endmodule : field_width
`default_nettype wire

// File: core/opcode_decoder.sv
// Summary of operation
// - 0F B[111w] ModRM: sign-extend move, one clock
// - 0F B[011w] ModRM: zero-extend move, one clock
// - 0F FF invalid: IF modified, trap_flag cleared
// - 0F 22 reg ModRM: control write 20/5/5
// - Full immediate is 8, 16, 32 bits
// - Displacement: 8 signed, or 16/32 by address
`timescale 1ns/10ps
`default_nettype none
module opcode_decoder (
	input  wire logic       MCLK,          // Core clock, 25 MHz
	input  wire logic       RST_N,         // Async reset, active low
	input  wire logic       BYTE_VALID,    // Fetched byte present
	input  wire logic [7:0] BYTE_IN,       // Fetched opcode byte
	input  wire logic       PROT_MODE,     // Protected mode in effect
	input  wire logic       OP32,          // Operand size is 32
	input  wire logic       ADDR32,        // Address size is 32
	input  wire logic       IMM_FULL_IN,   // Encoding carries full imm
	input  wire logic       IMM_BYTE_IN,   // Encoding carries 8-bit imm
	input  wire logic       DISP_FULL_IN,  // Encoding carries full disp
	input  wire logic       DISP_BYTE_IN,  // Encoding carries short disp
	output logic            DEC_VALID,     // One-cycle decode strobe
	output logic      [2:0] DEC_CLASS,     // Instruction class
	output logic      [1:0] OPND_WID,      // Operand width code
	output logic      [1:0] IMM_WID,       // Immediate width code
	output logic      [1:0] DISP_WID,      // Displacement width code
	output logic      [2:0] CTRL_SEL,      // Target control register
	output logic      [1:0] IF_EFFECT,     // Interrupt flag effect
	output logic      [1:0] TRAP_EFFECT,   // trap_flag effect
	output logic      [6:0] CLK_MIN,       // Least clock count
	output logic      [6:0] CLK_MAX        // Greatest clock count
);

	// ***********************************************
	// State
	// ***********************************************
	// Gray codes along escape, opcode, ModRM
	typedef enum logic [1:0] {
		ST_FIRST  = 2'h0, // Awaiting first byte
		ST_SECOND = 2'h1, // Awaiting second byte
		ST_MODRM  = 2'h3  // Awaiting ModRM byte
	} dec_state_t;

	// All sequencer and output state in one word
	typedef struct packed {
		dec_state_t st;        // Sequencer state
		logic [7:0] op2;       // Second opcode byte
		logic       valid;     // Decode strobe
		logic [2:0] cls;       // Class
		logic [1:0] opnd;      // Operand width
		logic [1:0] imm;       // Immediate width
		logic [1:0] disp;      // Displacement width
		logic [2:0] csel;      // Control register select
		logic [1:0] ifx;       // IF effect
		logic [1:0] tfx;       // trap_flag effect
		logic [6:0] cmin;      // Least clocks
		logic [6:0] cmax;      // Greatest clocks
	} dec_regs_t;

	// Register pair and widths worked out by the helper
	dec_regs_t  s_reg;   // Registered state
	dec_regs_t  s_next;  // Next state
	logic [1:0] imm_w;   // Immediate width from helper
	logic [1:0] disp_w;  // Displacement width from helper
	logic [1:0] opnd_w;  // Operand width from helper

	// ***********************************************
	// Decode helpers
	// ***********************************************
	// Latency of a control register write
	function automatic logic [6:0] ctrl_lat(input logic [2:0] sel);
		case (sel)
			3'h0:    ctrl_lat = opdec_pkg::LAT_CTRL0_WRITE;
			3'h2:    ctrl_lat = opdec_pkg::LAT_CTRL2_WRITE;
			3'h3:    ctrl_lat = opdec_pkg::LAT_CTRL3_WRITE;
			// Unreachable: other selectors are refused first
			default: ctrl_lat = opdec_pkg::LAT_CTRL0_WRITE;
		endcase
	endfunction : ctrl_lat

	// Register-form ModRM naming control reg 0, 2 or 3
	function automatic logic ctrl_target_ok(input logic [7:0] modrm);
		logic [2:0] sel; // Middle field of ModRM
		sel = modrm[5:3];
		ctrl_target_ok = modrm[7:6] == opdec_pkg::MODRM_REG_FORM &&
			(sel == 3'h0 || sel == 3'h2 || sel == 3'h3);
	endfunction : ctrl_target_ok

	// Second byte opens an instruction that needs a ModRM
	function automatic logic wants_modrm(input logic [7:0] op);
		wants_modrm = op[7:1] == opdec_pkg::SIGN_EXT_HI ||
			op[7:1] == opdec_pkg::ZERO_EXT_HI ||
			op == opdec_pkg::CTRL_WRITE_BYTE;
	endfunction : wants_modrm

	// Bit 3 of the opcode parts sign from zero extension
	function automatic logic [2:0] ext_class(input logic [7:0] op);
		ext_class = op[3] ? opdec_pkg::CLS_SIGN_EXT :
			opdec_pkg::CLS_ZERO_EXT;
	endfunction : ext_class

	// ***********************************************
	// Field widths
	// ***********************************************
	// Operand and immediate widths follow the w bit of the held opcode
	field_width u_width (
		.imm_full  (IMM_FULL_IN),
		.imm_byte  (IMM_BYTE_IN),
		.disp_full (DISP_FULL_IN),
		.disp_byte (DISP_BYTE_IN),
		.op32      (OP32),
		.addr32    (ADDR32),
		.w_bit     (s_reg.op2[0]),
		.imm_wid   (imm_w),
		.disp_wid  (disp_w),
		.opnd_wid  (opnd_w)
	);

	// ***********************************************
	// Next state
	// ***********************************************
	// Walk escape, second byte, ModRM; emit one strobe
	always_comb begin
		// Strobe drops unless a decode completes
		s_next       = s_reg;
		s_next.valid = 1'b0;
		case (s_reg.st)
			ST_FIRST: begin
				// Only the escape byte opens a walk
				if (BYTE_VALID && BYTE_IN == opdec_pkg::ESCAPE_BYTE)
					s_next.st = ST_SECOND;
			end
			ST_SECOND: begin
				// Escape seen; the opcode proper decides the walk
				if (BYTE_VALID) begin
					s_next.op2 = BYTE_IN;
					s_next.st  = ST_FIRST;
					if (BYTE_IN == opdec_pkg::INVALID_OP_BYTE) begin
						// Completes on this byte, no ModRM follows
						s_next.valid = 1'b1;
						s_next.cls   = opdec_pkg::CLS_INVALID;
						s_next.ifx   = opdec_pkg::FLG_MOD;
						s_next.tfx   = opdec_pkg::FLG_CLR;
						s_next.opnd  = opdec_pkg::WID_NONE;
						s_next.imm   = opdec_pkg::WID_NONE;
						s_next.disp  = opdec_pkg::WID_NONE;
						s_next.csel  = 3'h0;
						// Real mode one clock, protected a range
						s_next.cmin  = PROT_MODE ?
							opdec_pkg::LAT_INV_PROT_MIN : opdec_pkg::LAT_ONE;
						s_next.cmax  = PROT_MODE ?
							opdec_pkg::LAT_INV_PROT_MAX : opdec_pkg::LAT_ONE;
					end else if (wants_modrm(BYTE_IN)) begin
						// Known opcode, ModRM byte still to come
						s_next.st = ST_MODRM;
					end
					// Unknown opcodes fall back to idle silently
				end
			end
			ST_MODRM: begin
				// ModRM closes the instruction
				if (BYTE_VALID) begin
					s_next.st = ST_FIRST;
					if (s_reg.op2 == opdec_pkg::CTRL_WRITE_BYTE) begin
						// Refused forms leave every output standing
						if (ctrl_target_ok(BYTE_IN)) begin
							s_next.valid = 1'b1;
							s_next.cls   = opdec_pkg::CLS_CTRL_MOVE;
							s_next.csel  = BYTE_IN[5:3];
							s_next.opnd  = opdec_pkg::WID_32;
							s_next.imm   = opdec_pkg::WID_NONE;
							s_next.disp  = opdec_pkg::WID_NONE;
							s_next.ifx   = opdec_pkg::FLG_KEEP;
							s_next.tfx   = opdec_pkg::FLG_KEEP;
							s_next.cmin  = ctrl_lat(BYTE_IN[5:3]);
							s_next.cmax  = ctrl_lat(BYTE_IN[5:3]);
						end
					end else begin
						// Extending move, widths from the helper
						s_next.valid = 1'b1;
						s_next.cls   = ext_class(s_reg.op2);
						s_next.opnd  = opnd_w;
						s_next.imm   = imm_w;
						s_next.disp  = disp_w;
						s_next.ifx   = opdec_pkg::FLG_KEEP;
						s_next.tfx   = opdec_pkg::FLG_KEEP;
						s_next.csel  = 3'h0;
						s_next.cmin  = opdec_pkg::LAT_ONE;
						s_next.cmax  = opdec_pkg::LAT_ONE;
					end
				end
			end
			// Unused code: recover to idle
			default: s_next.st = ST_FIRST;
		endcase
	end

	// ***********************************************
	// State register
	// ***********************************************
	// Async clear; outputs read zero until a decode
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// ***********************************************
	// Outputs
	// ***********************************************
	// Outputs straight from flops
	assign DEC_VALID   = s_reg.valid;
	assign DEC_CLASS   = s_reg.cls;
	assign OPND_WID    = s_reg.opnd;
	assign IMM_WID     = s_reg.imm;
	assign DISP_WID    = s_reg.disp;
	assign CTRL_SEL    = s_reg.csel;
	assign IF_EFFECT   = s_reg.ifx;
	assign TRAP_EFFECT = s_reg.tfx;
	assign CLK_MIN     = s_reg.cmin;
	assign CLK_MAX     = s_reg.cmax;

endmodule : opcode_decoder
`default_nettype wire

// File: testbench/opdec_properties.sv
`timescale 1ns/10ps
`default_nettype none
// ***********************************************
// Decoder port checker
// ***********************************************
module opdec_properties (
	input wire logic       MCLK,         // Clock
	input wire logic       RST_N,        // Reset
	input wire logic       BYTE_VALID,   // Byte present
	input wire logic [7:0] BYTE_IN,      // Byte
	input wire logic       PROT_MODE,    // Mode
	input wire logic       OP32,         // Operand size
	input wire logic       ADDR32,       // Address size
	input wire logic       IMM_FULL_IN,  // Full imm
	input wire logic       DISP_FULL_IN, // Full disp
	input wire logic       DEC_VALID,    // Strobe
	input wire logic [2:0] DEC_CLASS,    // Class
	input wire logic [1:0] OPND_WID,     // Operand width
	input wire logic [1:0] IMM_WID,      // Imm width
	input wire logic [1:0] DISP_WID,     // Disp width
	input wire logic [1:0] IF_EFFECT,    // Interrupt flag
	input wire logic [1:0] TRAP_EFFECT,  // Trap flag
	input wire logic [6:0] CLK_MIN,      // Least count
	input wire logic [6:0] CLK_MAX       // Greatest count
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	// Escape byte, then a masked second byte
	sequence s_esc(logic [7:0] m, logic [7:0] v);
		BYTE_VALID && BYTE_IN == 8'h0f
		##1 BYTE_VALID && (BYTE_IN & m) == v;
	endsequence
	a_sext_class: assert property (s_esc(8'hfe, 8'hbe) ##1 BYTE_VALID
		|=> DEC_VALID && DEC_CLASS == 3'h1 && CLK_MAX == 7'h01)
		else $error("sign extend decode wrong");
	a_zext_class: assert property (s_esc(8'hfe, 8'hb6) ##1 BYTE_VALID
		|=> DEC_VALID && DEC_CLASS == 3'h2 && CLK_MIN == 7'h01)
		else $error("zero extend decode wrong");
	a_invalid_flags: assert property (s_esc(8'hff, 8'hff)
		|=> DEC_VALID && IF_EFFECT == 2'h1 && TRAP_EFFECT == 2'h2)
		else $error("invalid op flags wrong");
	a_invalid_clocks: assert property (s_esc(8'hff, 8'hff) |=>
		CLK_MIN == ($past(PROT_MODE) ? 7'h08 : 7'h01)
		&& CLK_MAX == ($past(PROT_MODE) ? 7'h7d : 7'h01))
		else $error("invalid op clocks wrong");
	a_ctrl_latency: assert property (s_esc(8'hff, 8'h22)
		##1 BYTE_VALID && BYTE_IN[7:6] == 2'h3
		&& BYTE_IN[5:3] inside {3'h0, 3'h2, 3'h3} |=> DEC_VALID
		&& CLK_MAX == ($past(BYTE_IN[5:3]) == 3'h0 ? 7'h14 : 7'h05))
		else $error("control write latency wrong");
	a_ctrl_refuse: assert property (s_esc(8'hff, 8'h22)
		##1 BYTE_VALID && BYTE_IN[7:6] != 2'h3 |=> !DEC_VALID)
		else $error("control write not refused");
	a_imm_width: assert property (s_esc(8'hf7, 8'hb7)
		##1 BYTE_VALID && IMM_FULL_IN
		|=> IMM_WID == ($past(OP32) ? 2'h3 : 2'h2))
		else $error("immediate width wrong");
	a_disp_width: assert property (s_esc(8'hf6, 8'hb6)
		##1 BYTE_VALID && DISP_FULL_IN
		|=> DISP_WID == ($past(ADDR32) ? 2'h3 : 2'h2))
		else $error("displacement width wrong");
	a_wbit_width: assert property (s_esc(8'hf7, 8'hb6)
		##1 BYTE_VALID |=> OPND_WID == 2'h1)
		else $error("byte operand width wrong");
endmodule : opdec_properties
bind opcode_decoder opdec_properties u_opdec_properties (.*);
`default_nettype wire

// File: testbench/fetch_model.sv
`timescale 1ns/10ps
`default_nettype none
// Fetch stage stand-in, one byte a cycle
module fetch_model (
	input  wire logic       clk,   // Core clock
	output logic            vld,   // Byte present
	output logic      [7:0] byte_o // Fetched byte
);
	initial begin
		vld = 1'b0;
		byte_o = 8'h00;
	end
	// Offer one byte
	task put(input logic [7:0] b);
		@(posedge clk);
		vld <= 1'b1;
		byte_o <= b;
	endtask : put
	// Release; stale data is inverted
	task idle();
		@(posedge clk);
		vld <= 1'b0;
		byte_o <= ~byte_o;
	endtask : idle
endmodule : fetch_model
`default_nettype wire

// File: testbench/opcode_decoder_tb.sv
`timescale 1ns/10ps
`default_nettype none
module opcode_decoder_tb;
	logic       mclk, rst_n, vld, dv;      // Clock, reset, strobes
	logic       prot, op32, addr32;        // Modes
	logic       imm_full, imm_byte, disp_full; // Field presence
	logic [7:0] byte_in;                   // Fetched byte
	logic [2:0] cls, sel;                  // Class, control reg
	logic [1:0] ow, iw, dw, ife, tfe;      // Widths, flags
	logic [6:0] cmin, cmax;                // Clock counts
	int         error_cnt = 0;             // Mismatches
	int         samples_checked = 0;       // Comparisons
	fetch_model u_fetch_model (.clk(mclk), .vld(vld), .byte_o(byte_in));
	opcode_decoder u_opcode_decoder (.MCLK(mclk), .RST_N(rst_n),
		.BYTE_VALID(vld), .BYTE_IN(byte_in), .PROT_MODE(prot),
		.OP32(op32), .ADDR32(addr32), .IMM_FULL_IN(imm_full),
		.IMM_BYTE_IN(imm_byte), .DISP_FULL_IN(disp_full),
		.DISP_BYTE_IN(!disp_full), .DEC_VALID(dv), .DEC_CLASS(cls),
		.OPND_WID(ow), .IMM_WID(iw), .DISP_WID(dw), .CTRL_SEL(sel),
		.IF_EFFECT(ife), .TRAP_EFFECT(tfe), .CLK_MIN(cmin),
		.CLK_MAX(cmax));
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// Compare and count
	task chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
			error_cnt++;
		end
	endtask : chk
	// Send one instruction, then judge the strobe
	task dec(input logic [7:0] b2, input logic [7:0] m,
		input logic [7:0] ev);
		u_fetch_model.put(8'h0f);
		u_fetch_model.put(b2);
		if (b2 != 8'hff) u_fetch_model.put(m);
		u_fetch_model.idle();
		#1;
		chk(dv, ev);
	endtask : dec
	// Extending moves over w, sizes, displacement kinds
	task t_ext();
		logic [7:0] e;
		for (int i = 0; i < 16; i++) begin
			@(posedge mclk);
			op32 <= i[2];
			addr32 <= i[2];
			disp_full <= i[0];
			imm_full <= !i[3];
			imm_byte <= i[3];
			e = !i[0] ? 8'h01 : i[2] ? 8'h03 : 8'h02;
			dec(8'hb6 | {4'h0, i[1], 2'h0, i[0]}, 8'hc1, 8'h01);
			chk(cls, i[1] ? 8'h01 : 8'h02);
			chk(cmax, 8'h01);
			chk(ow, e);
			chk(iw, i[3] ? 8'h01 : e);
			chk(dw, e);
		end
		$display("extend test done");
	endtask : t_ext
	// Invalid opcode in both modes, after a stray byte
	task t_inv();
		for (int p = 0; p < 2; p++) begin
			@(posedge mclk);
			prot <= p[0];
			u_fetch_model.put(8'h90);
			dec(8'hff, 8'h00, 8'h01);
			chk(cls, 8'h03);
			chk(ife, 8'h01);
			chk(tfe, 8'h02);
			chk(cmin, p ? 8'h08 : 8'h01);
			chk(cmax, p ? 8'h7d : 8'h01);
		end
		$display("invalid test done");
	endtask : t_inv
	// Control writes, legal and refused
	task t_ctrl();
		logic [7:0] rm [5] = '{8'hc0, 8'hd0, 8'hd8, 8'hc8, 8'h18};
		for (int i = 0; i < 5; i++) begin
			dec(8'h22, rm[i], {7'h0, i < 3});
			if (i < 3) begin
				chk(sel, {5'h0, rm[i][5:3]});
				chk(cmin, i == 0 ? 8'h14 : 8'h05);
				chk(cls, 8'h04);
			end else begin
				// Refused writes leave the last target standing
				chk(sel, 8'h03);
			end
		end
		$display("control test done");
	endtask : t_ctrl
	// Verdict
	task summarize();
		$display("checked %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : summarize
	initial begin
		rst_n = 1'b0;
		prot = 1'b0;
		op32 = 1'b0;
		addr32 = 1'b0;
		imm_full = 1'b1;
		imm_byte = 1'b0;
		disp_full = 1'b0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		t_ext();
		t_inv();
		t_ctrl();
		summarize();
	end
endmodule : opcode_decoder_tb
`default_nettype wire
